//--- inc/psm_pkg.sv
package psm_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] PSC_ADDR  = 8'h87;
    localparam logic [7:0] PSC_RESET = 8'h00;
    localparam int BIT_IDLE = 0;
    localparam int BIT_PD   = 1;
    localparam int BIT_TCK2 = 2;
    localparam int BIT_RCK2 = 3;
    localparam int BIT_ADCI = 4;
    localparam int BIT_LVRD = 5;
    localparam int BIT_SMD2 = 6;
    localparam int BIT_SMD1 = 7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PER_MC      = 12;
    localparam int RESTART_MC      = 3;
    localparam int RESTART_CYCLES  = RESTART_MC * CLK_PER_MC;

    // mode encoding
    typedef enum logic [1:0] {
        PSM_RUN  = 2'b00,
        PSM_IDLE = 2'b01,
        PSM_PDN  = 2'b10,
        PSM_RST  = 2'b11
    } psm_state_type;

    // special-function register write port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psm_sfr_type;
endpackage

//--- hw/psm_ctrl.sv
`timescale 1ns/10ps
module psm_ctrl
    import psm_pkg::*;
(
    input  wire logic               SYS_CLK,
    input  wire logic               RSTN,
    input  wire psm_pkg::psm_sfr_type SFR,
    input  wire logic               IRQ_PENDING,
    input  wire logic               INT_RESET,
    output logic [7:0]              SFR_RDATA,
    output logic                    CPU_HALT,
    output logic                    CLK_RUN,
    output logic                    PERIPH_RUN,
    output logic                    LVR_ENABLE,
    output logic                    LVD_ENABLE,
    output logic                    UART1_BAUD_X2,
    output logic                    UART2_BAUD_X2,
    output logic                    UART2_RX_CLK,
    output logic                    UART2_TX_CLK,
    output logic                    ADC_INT_EN,
    output logic                    CPU_START
);
    import psm_pkg::*;

    logic [7:0]    psc_ff;
    logic [7:0]    nxt_psc;
    psm_state_type state_ff;
    psm_state_type nxt_state;
    logic [5:0]    cnt_ff;
    logic [5:0]    nxt_cnt;
    logic          irq_s1_ff;
    logic          irq_s2_ff;
    logic          irst_s1_ff;
    logic          irst_s2_ff;
    logic [7:0]    rdata_ff;
    logic          halt_ff;
    logic          clk_ff;
    logic          per_ff;
    logic          start_ff;
    logic          lvr_ff;
    logic          lvd_ff;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire sel     = (SFR.addr == PSC_ADDR);
    // core is halted outside run, so any stray write there is dropped;
    // this also keeps every field frozen through power-down, and through idle until a wake or internal reset
    wire wr_hit  = SFR.wr & sel & (state_ff == PSM_RUN);
    wire req_pd  = wr_hit & SFR.wdata[BIT_PD];
    wire req_idl = wr_hit & SFR.wdata[BIT_IDLE] & ~SFR.wdata[BIT_PD];
    // wake only from idle; power-down ignores interrupts
    wire wake    = (state_ff == PSM_IDLE) & irq_s2_ff;
    // internal reset out of idle; it wins over a wake in the same cycle
    wire irst_hit = (state_ff == PSM_IDLE) & irst_s2_ff;

    // register next value: hardware clears the idle bit on a power-down write and on idle wake
    always_comb begin
        nxt_psc = psc_ff;
        if (wr_hit) begin
            nxt_psc = SFR.wdata;
        end
        if (wr_hit && SFR.wdata[BIT_PD]) begin
            nxt_psc[BIT_IDLE] = 1'b0;
        end
        if (wake) begin
            nxt_psc[BIT_IDLE] = 1'b0;
        end
        // internal reset puts the register back to its defined state
        if (irst_hit) begin
            nxt_psc = PSC_RESET;
        end
    end

    // mode machine; internal reset counts a fixed restart delay
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            PSM_RUN: begin
                if (req_pd) begin
                    nxt_state = PSM_PDN;
                end else if (req_idl) begin
                    nxt_state = PSM_IDLE;
                end
            end
            PSM_IDLE: begin
                if (irst_s2_ff) begin
                    nxt_state = PSM_RST;
                    nxt_cnt   = 6'(RESTART_CYCLES - 1);
                end else if (wake) begin
                    nxt_state = PSM_RUN;
                end
            end
            PSM_PDN: begin
                nxt_state = PSM_PDN;
            end
            PSM_RST: begin
                if (cnt_ff == 6'h00) begin
                    nxt_state = PSM_RUN;
                end else begin
                    nxt_cnt = cnt_ff - 6'h01;
                end
            end
            default: nxt_state = PSM_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // reset returns to run with low-voltage reset enabled
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            psc_ff   <= PSC_RESET;
            state_ff <= PSM_RUN;
            cnt_ff   <= 6'h00;
        end else begin
            psc_ff   <= nxt_psc;
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // two-stage syncs for pin-side inputs
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_s1_ff  <= 1'b0;
            irq_s2_ff  <= 1'b0;
            irst_s1_ff <= 1'b0;
            irst_s2_ff <= 1'b0;
        end else begin
            irq_s1_ff  <= IRQ_PENDING;
            irq_s2_ff  <= irq_s1_ff;
            irst_s1_ff <= INT_RESET;
            irst_s2_ff <= irst_s1_ff;
        end
    end

    // outputs: halt blocks core so its state stays frozen
    wire nh = (nxt_state != PSM_RUN);
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            halt_ff  <= 1'b0;
            clk_ff   <= 1'b1;
            per_ff   <= 1'b1;
            start_ff <= 1'b0;
            rdata_ff <= PSC_RESET;
            lvr_ff   <= 1'b1;
            lvd_ff   <= 1'b1;
        end else begin
            halt_ff  <= nh;
            clk_ff   <= (nxt_state != PSM_PDN);
            per_ff   <= (nxt_state != PSM_PDN);
            start_ff <= (state_ff == PSM_RST) & (cnt_ff == 6'h00);
            rdata_ff <= nxt_psc;
            // registered from the next value so it tracks the field exactly
            lvr_ff   <= ~nxt_psc[BIT_LVRD];
            // detector never switched off, not even in power-down
            lvd_ff   <= 1'b1;
        end
    end

    assign SFR_RDATA     = rdata_ff;
    assign CPU_HALT      = halt_ff;
    assign CLK_RUN       = clk_ff;
    assign PERIPH_RUN    = per_ff;
    assign CPU_START     = start_ff;
    assign LVR_ENABLE    = lvr_ff;
    assign LVD_ENABLE    = lvd_ff;
    assign UART1_BAUD_X2 = psc_ff[BIT_SMD1];
    assign UART2_BAUD_X2 = psc_ff[BIT_SMD2];
    assign UART2_RX_CLK  = psc_ff[BIT_RCK2];
    assign UART2_TX_CLK  = psc_ff[BIT_TCK2];
    assign ADC_INT_EN    = psc_ff[BIT_ADCI];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // internal reset seen while idle
    sequence s_idle_reset;
        state_ff == PSM_IDLE && irst_s2_ff;
    endsequence

    // last restart cycle, then run with the start pulse
    sequence s_restart_done;
        state_ff == PSM_RST ##1 (state_ff == PSM_RUN && CPU_START);
    endsequence

    // wake that is not overridden by a reset
    sequence s_clean_wake;
        wake && !irst_s2_ff;
    endsequence

    a_pd_sticks: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_ff == PSM_PDN |=> state_ff == PSM_PDN) else $error("power-down left without reset");
    a_idle_enter: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_ff == PSM_RUN && req_idl |=> state_ff == PSM_IDLE ##1 CPU_HALT) else $error("idle not entered");
    a_pd_enter: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_ff == PSM_RUN && req_pd |=> ##1 !CLK_RUN && !PERIPH_RUN) else $error("power-down not entered");
    a_wake_clear: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        s_clean_wake |=> !psc_ff[BIT_IDLE] && state_ff == PSM_RUN) else $error("idle wake failed");
    a_both_pd: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_ff == PSM_RUN && wr_hit && SFR.wdata[BIT_PD] && SFR.wdata[BIT_IDLE]
        |=> state_ff == PSM_PDN && !psc_ff[BIT_IDLE]) else $error("both bits not power-down");
    a_lvr_bit: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        LVR_ENABLE != psc_ff[BIT_LVRD]) else $error("lvr enable wrong");
    a_restart_len: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        s_idle_reset |=> ##35 s_restart_done)
        else $error("restart delay wrong");
    a_idle_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_ff == PSM_IDLE && !irq_s2_ff && !irst_s2_ff |=> state_ff == PSM_IDLE) else $error("idle left early");
    a_wake_run: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        s_clean_wake |=> !CPU_HALT) else $error("core not released on wake");
    a_start_pulse: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        CPU_START |=> !CPU_START) else $error("start pulse too long");
    a_irst_clear: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        s_idle_reset |=> psc_ff == PSC_RESET && CPU_HALT) else $error("internal reset left fields");
    a_pd_outputs: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_ff == PSM_PDN |-> !CLK_RUN && !PERIPH_RUN && CPU_HALT && LVD_ENABLE)
        else $error("power-down outputs wrong");
    a_pd_frozen: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_ff == PSM_PDN |=> $stable(psc_ff)) else $error("register changed in power-down");
    a_idle_frozen: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        state_ff == PSM_IDLE && !wake && !irst_s2_ff |=> $stable(psc_ff))
        else $error("register changed in idle");
endmodule

//--- testbench/psm_core_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// core side: register writes and wake or reset requests
// ------------------------------------------------------------
module psm_core_model
    import psm_pkg::*;
(
    input  wire logic            SYS_CLK,
    output psm_pkg::psm_sfr_type SFR,
    output logic                 IRQ_PENDING,
    output logic                 INT_RESET
);
    // quiet bus and no requests at time zero
    initial begin
        SFR = '0;
        IRQ_PENDING = 1'b0;
        INT_RESET = 1'b0;
    end
    // one-cycle write, then the bus is released; halt is not checked, so writes are still issued while halted
    // released bus shows the complement so a stale byte never looks valid
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        #1;
        SFR = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge SYS_CLK);
        #1;
        SFR = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // level requests, held until changed; core state is untouched meanwhile
    task automatic set_req(input logic irq, input logic rst);
        @(posedge SYS_CLK);
        #1;
        IRQ_PENDING = irq;
        INT_RESET = rst;
    endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display("Error %s exp %h seen %h", nm, e, g); end end
module tb_top;
    import psm_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    psm_sfr_type sfr;
    logic        irq_pending, int_reset, cpu_halt, clk_run, periph_run, lvr_enable, lvd_enable;
    logic        uart1_x2, uart2_x2, uart2_rx, uart2_tx, adc_int_en, cpu_start;
    logic [7:0]  sfr_rdata;
    int          errors = 0;
    int          tests_run = 0;
    int          n;
    always #2 sys_clk = ~sys_clk;
    psm_core_model u_psm_core_model (.SYS_CLK(sys_clk), .SFR(sfr), .IRQ_PENDING(irq_pending),
        .INT_RESET(int_reset));
    psm_ctrl u_psm_ctrl (.SYS_CLK(sys_clk), .RSTN(rstn), .SFR(sfr), .IRQ_PENDING(irq_pending),
        .INT_RESET(int_reset), .SFR_RDATA(sfr_rdata), .CPU_HALT(cpu_halt), .CLK_RUN(clk_run),
        .PERIPH_RUN(periph_run), .LVR_ENABLE(lvr_enable), .LVD_ENABLE(lvd_enable),
        .UART1_BAUD_X2(uart1_x2), .UART2_BAUD_X2(uart2_x2), .UART2_RX_CLK(uart2_rx),
        .UART2_TX_CLK(uart2_tx), .ADC_INT_EN(adc_int_en), .CPU_START(cpu_start));
    // ------------------------------------------------------------
    // helpers: settle just after an edge, so outputs have landed
    // ------------------------------------------------------------
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_psm_core_model.sfr_write(a, d);
        tick(1);
    endtask
    // mid-run reset kept two machine cycles long
    task automatic do_reset();
        rstn = 1'b0;
        tick(2 * CLK_PER_MC);
        rstn = 1'b1;
        tick(1);
    endtask
    task automatic give_verdict();
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #20000;
        errors++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        tick(2);
        rstn = 1'b1;
        tick(1);
        `CHK("reset value", PSC_RESET, sfr_rdata)
        `CHK("lvr default", 1'b1, lvr_enable)
        wr(PSC_ADDR, 8'hFC);
        `CHK("fields", 8'hFC, sfr_rdata)
        `CHK("lvr off", 1'b0, lvr_enable)
        `CHK("baud x2", 2'b11, {uart1_x2, uart2_x2})
        `CHK("uart2 flags", 3'b111, {uart2_rx, uart2_tx, adc_int_en})
        `CHK("no halt", 1'b0, cpu_halt)
        wr(8'h88, 8'h00);
        `CHK("other addr", 8'hFC, sfr_rdata)
        wr(PSC_ADDR, 8'h81);
        `CHK("idle halt", 3'b111, {cpu_halt, clk_run, periph_run})
        `CHK("idle fields", 6'b110000, {lvr_enable, uart1_x2, uart2_x2, uart2_rx, uart2_tx, adc_int_en})
        u_psm_core_model.set_req(1'b1, 1'b0);
        n = 0;
        while (cpu_halt !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        `CHK("irq wake", 1'b0, cpu_halt)
        `CHK("idle cleared", 8'h80, sfr_rdata)
        u_psm_core_model.set_req(1'b0, 1'b0);
        tick(4);
        wr(PSC_ADDR, 8'h01);
        u_psm_core_model.set_req(1'b0, 1'b1);
        n = 0;
        while (cpu_start !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        `CHK("restart span", 1'b1, n >= RESTART_CYCLES && n <= RESTART_CYCLES + 4)
        u_psm_core_model.set_req(1'b0, 1'b0);
        tick(4);
        `CHK("running", 1'b0, cpu_halt)
        `CHK("restart regs", PSC_RESET, sfr_rdata)
        wr(PSC_ADDR, 8'h12);
        `CHK("pd clocks", 4'b1001, {cpu_halt, clk_run, periph_run, lvd_enable})
        u_psm_core_model.set_req(1'b1, 1'b0);
        tick(30);
        `CHK("pd no wake", 1'b1, cpu_halt)
        wr(PSC_ADDR, 8'h00);
        `CHK("pd kept", 8'h12, sfr_rdata)
        u_psm_core_model.set_req(1'b0, 1'b0);
        do_reset();
        `CHK("pd reset", 9'h100, {clk_run, sfr_rdata})
        wr(PSC_ADDR, 8'h03);
        `CHK("both bits", 9'h002, {clk_run, sfr_rdata})
        do_reset();
        give_verdict();
    end
endmodule
